// ==== rtl/fcp_controller.sv ====
// Host controller that programs bytes and polls flash for completion
// Functional notes
// - Byte program is four writes; only the last carries address and byte.
// - Poll address is program address, or an address inside the erased sector.
// - Read poll address; poll bit equal to data passes, else reread if no timeout.
// - On timeout flag, read once more; pass if poll bit matches, else fail.
// - Toggle method reads twice; running only if toggle bit differs.
// - On timeout flag in toggle polling, recheck; fail only if still toggling.
`timescale 1ns/1ps
`default_nettype none
module fcp_controller
#(
	parameter longint ERASE_LIMIT_CYC = fcp_pkg::ERASE_MAX_CYC
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic op_start,
	input wire logic op_program,
	input wire fcp_pkg::fcp_meth_t op_method,
	input wire logic [fcp_pkg::ADDR_W-1:0] op_addr,
	input wire logic [fcp_pkg::DATA_W-1:0] op_data,
	output logic op_ready,
	output logic op_done,
	output logic op_pass,
	output logic op_watchdog,
	output logic [fcp_pkg::ADDR_W-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	input wire logic [fcp_pkg::DATA_W-1:0] flash_dq_in,
	output logic [fcp_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe
);
	import fcp_pkg::*;
	// Refuse a limit that the watchdog counter cannot hold
	if (ERASE_LIMIT_CYC < 1 || ERASE_LIMIT_CYC > 64'h00000000ffffffff)
	begin : gen_limit_check
		$error("ERASE_LIMIT_CYC out of range");
	end
	// ****************************************
	// State machine
	// ****************************************
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_POLL_A = 3'b010,
		ST_POLL_B = 3'b011,
		ST_RECHECK = 3'b100,
		ST_FINISH = 3'b101
	} fcp_state_t;
	fcp_state_t state;
	fcp_meth_t method;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	logic [1:0] cmd_idx;
	logic [DATA_W-1:0] prev_byte;
	logic timeout_seen;
	logic [TIMER_W-1:0] timer;
	logic cyc_start;
	logic cyc_write;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_wdata;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic issued;
	// ****************************************
	// Command sequence decode
	// ****************************************
	// Address and data of write number idx of the program sequence
	function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(input logic [1:0] idx,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		case (idx)
			2'h0: cmd_word = {UNLOCK_ADDR1, UNLOCK_DATA1};
			2'h1: cmd_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
			2'h2: cmd_word = {UNLOCK_ADDR1, PROGRAM_CMD};
			default: cmd_word = {a, d}; // Target address and byte last
		endcase
	endfunction
	wire [ADDR_W+DATA_W-1:0] cmd_now = cmd_word(cmd_idx, addr, data);
	wire in_poll = (state == ST_POLL_A) || (state == ST_POLL_B) || (state == ST_RECHECK);
	wire poll_match = cyc_rdata[POLL_BIT] == data[POLL_BIT];
	wire toggled = cyc_rdata[TOGGLE_BIT] != prev_byte[TOGGLE_BIT];
	wire timeout_flag = cyc_rdata[TIMEOUT_BIT];
	wire watchdog_hit = timer == TIMER_W'(ERASE_LIMIT_CYC - 1);
	assign op_ready = (state == ST_IDLE);
	// Bus cycle requests: writes during command, reads at poll address while polling
	assign cyc_start = ((state == ST_CMD) || in_poll) && !issued;
	assign cyc_write = (state == ST_CMD);
	assign cyc_addr = (state == ST_CMD) ? cmd_now[ADDR_W+DATA_W-1:DATA_W] : addr;
	assign cyc_wdata = cmd_now[DATA_W-1:0];
	// Issued flag marks a bus cycle in flight
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			issued <= 1'b0;
		else if (cyc_done)
			issued <= 1'b0;
		else if (cyc_start)
			issued <= 1'b1;
	end
	// Watchdog from the start of the operation, bounded by the worst erase time; only ST_POLL_A acts on it
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			timer <= '0;
		else if (state == ST_IDLE)
			timer <= '0;
		else if (!watchdog_hit)
			timer <= timer + 1'b1;
	end
	// Main sequencer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			method <= METH_DATA;
			addr <= '0;
			data <= '0;
			cmd_idx <= 2'h0;
			prev_byte <= '0;
			timeout_seen <= 1'b0;
			op_done <= 1'b0;
			op_pass <= 1'b0;
			op_watchdog <= 1'b0;
		end
		else
		begin
			op_done <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (op_start)
					begin
						method <= op_method;
						addr <= op_addr;
						data <= op_data;
						cmd_idx <= 2'h0;
						timeout_seen <= 1'b0;
						op_watchdog <= 1'b0;
						state <= op_program ? ST_CMD : ST_POLL_A;
					end
				end
				ST_CMD:
				begin
					if (cyc_done)
					begin
						cmd_idx <= cmd_idx + 2'h1;
						if (cmd_idx == 2'(PROGRAM_WRITES - 1))
							state <= ST_POLL_A;
					end
				end
				ST_POLL_A:
				begin
					if (cyc_done)
					begin
						prev_byte <= cyc_rdata;
						if (method == METH_DATA)
						begin
							if (poll_match)
							begin
								op_pass <= 1'b1;
								state <= ST_FINISH;
							end
							else if (timeout_flag)
								state <= ST_RECHECK;
						end
						else
							state <= ST_POLL_B;
					end
					else if (watchdog_hit)
					begin
						op_watchdog <= 1'b1;
						op_pass <= 1'b0;
						state <= ST_FINISH;
					end
				end
				ST_POLL_B:
				begin
					if (cyc_done)
					begin
						prev_byte <= cyc_rdata;
						if (!toggled)
						begin
							op_pass <= 1'b1;
							state <= ST_FINISH;
						end
						else if (timeout_seen)
						begin
							op_pass <= 1'b0; // Still toggling after the flag
							state <= ST_FINISH;
						end
						else if (timeout_flag)
						begin
							// A fresh pair of reads decides, toggling may just have stopped
							timeout_seen <= 1'b1;
							state <= ST_POLL_A;
						end
					end
				end
				ST_RECHECK:
				begin
					if (cyc_done)
					begin
						op_pass <= poll_match; // Only data polling rechecks here
						state <= ST_FINISH;
					end
				end
				ST_FINISH:
				begin
					if (!issued)
					begin
						op_done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
	// ****************************************
	// Bus cycle engine
	// ****************************************
	fcp_bus_cycle u_cycle
	(
		.clock(clock),
		.rst_n(rst_n),
		.start(cyc_start),
		.write(cyc_write),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_addr(flash_addr),
		.flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n),
		.flash_dq_in(flash_dq_in),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe)
	);
	// ****************************************
	// Checks
	// ****************************************
	program_four_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == ST_CMD && cyc_done && cmd_idx == 2'h3) |=> (state == ST_POLL_A))
		else $error("program sequence did not end after four writes");
	last_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(cyc_start && state == ST_CMD && cmd_idx == 2'h3) |-> (cyc_addr == addr && cyc_wdata == data))
		else $error("last write does not carry target address and byte");
	poll_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
		(cyc_start && in_poll) |-> (cyc_addr == addr && !cyc_write))
		else $error("poll read not at poll address");
	match_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == ST_POLL_A && method == METH_DATA && cyc_done && poll_match) |=> op_pass ##[1:40] op_done)
		else $error("poll match did not pass");
	timeout_reread_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == ST_POLL_A && method == METH_DATA && cyc_done && !poll_match && timeout_flag)
		|=> (state == ST_RECHECK))
		else $error("timeout did not trigger a reread");
	toggle_twice_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == ST_POLL_B && cyc_done && !toggled) |=> (op_pass && state == ST_FINISH))
		else $error("stable toggle bit not judged finished");
	toggle_recheck_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == ST_POLL_B && timeout_seen && cyc_done)
		|=> (state == ST_FINISH && op_pass != $past(toggled)))
		else $error("toggle recheck verdict wrong");
endmodule // fcp_controller
`default_nettype wire

// ==== inc/fcp_pkg.sv ====
// Constants shared by the flash completion polling controller
package fcp_pkg;
	// Address and data widths of the flash bus
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	// Status bit positions in a read byte
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	// Unlock command sequence for a byte program
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002aa;
	localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'haa;
	localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [DATA_W-1:0] PROGRAM_CMD = 8'ha0;
	localparam int PROGRAM_WRITES = 4;
	// Bus cycle timing in nanoseconds and the clock period
	localparam int CLK_PERIOD_NS = 8;
	localparam int WRITE_PULSE_NS = 50;
	localparam int WRITE_HIGH_NS = 20;
	localparam int READ_ACCESS_NS = 120;
	localparam int OE_HOLD_NS = 10;
	// Least times round up to whole cycles
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OE_HOLD_CYC = (OE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Sector erase limits in seconds (not counting preprogramming)
	localparam int ERASE_TYP_S = 1;
	localparam int ERASE_MAX_S = 8;
	localparam longint CLK_HZ = 125000000;
	localparam longint ERASE_MAX_CYC = ERASE_MAX_S * CLK_HZ;
	localparam int TIMER_W = 32;
	// Bus cycle kinds
	typedef enum logic [1:0]
	{
		CYC_IDLE = 2'b00,
		CYC_READ = 2'b01,
		CYC_WRITE = 2'b10
	} fcp_cyc_t;
	// Status polling methods
	typedef enum logic
	{
		METH_DATA = 1'b0,
		METH_TOGGLE = 1'b1
	} fcp_meth_t;
endpackage

// ==== rtl/fcp_bus_cycle.sv ====
// One asynchronous read or write cycle on the flash bus
`timescale 1ns/1ps
`default_nettype none
module fcp_bus_cycle
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic write,
	input wire logic [fcp_pkg::ADDR_W-1:0] addr,
	input wire logic [fcp_pkg::DATA_W-1:0] wdata,
	output logic done,
	output logic [fcp_pkg::DATA_W-1:0] rdata,
	output logic [fcp_pkg::ADDR_W-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	input wire logic [fcp_pkg::DATA_W-1:0] flash_dq_in,
	output logic [fcp_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe
);
	import fcp_pkg::*;
	// ****************************************
	// Phase timing
	// ****************************************
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'b00,
		PH_ACTIVE = 2'b01,
		PH_RECOVER = 2'b10
	} fcp_phase_t;
	fcp_phase_t phase;
	logic is_write;
	logic [7:0] count;
	wire [7:0] active_len = is_write ? 8'(WRITE_PULSE_CYC) : 8'(READ_ACCESS_CYC);
	wire [7:0] recover_len = is_write ? 8'(WRITE_HIGH_CYC) : 8'(OE_HOLD_CYC);
	wire count_end = (phase == PH_ACTIVE) ? (count == active_len - 8'h01)
		: (count == recover_len - 8'h01);
	assign done = (phase == PH_RECOVER) && count_end;
	// Sequencer: strobe low for the access time, then high for recovery
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase <= PH_IDLE;
			is_write <= 1'b0;
			count <= 8'h00;
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_oe_n <= 1'b1;
			rdata <= '0;
		end
		else
		begin
			case (phase)
				PH_IDLE:
				begin
					if (start)
					begin
						phase <= PH_ACTIVE;
						is_write <= write;
						count <= 8'h00;
						flash_addr <= addr;
						flash_dq_out <= wdata;
						flash_dq_oe <= write;
						flash_ce_n <= 1'b0;
						flash_we_n <= !write;
						flash_oe_n <= write;
					end
				end
				PH_ACTIVE:
				begin
					count <= count + 8'h01;
					if (count_end)
					begin
						phase <= PH_RECOVER;
						count <= 8'h00;
						if (!is_write)
							rdata <= flash_dq_in; // Sample read data at end of access
						flash_ce_n <= 1'b1;
						flash_we_n <= 1'b1;
						flash_oe_n <= 1'b1;
					end
				end
				PH_RECOVER:
				begin
					count <= count + 8'h01;
					if (count_end)
					begin
						phase <= PH_IDLE;
						flash_dq_oe <= 1'b0;
					end
				end
				default:
					phase <= PH_IDLE;
			endcase
		end
	end
endmodule // fcp_bus_cycle
`default_nettype wire

// ==== tb/fcp_flash_model.sv ====
// Behavioural flash device on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
// ****************
// Flash model
// ****************
module fcp_flash_model
(
	input wire logic clock,
	input wire logic [fcp_pkg::ADDR_W-1:0] flash_addr,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic [fcp_pkg::DATA_W-1:0] flash_dq_out,
	input wire logic flash_dq_oe,
	output logic [fcp_pkg::DATA_W-1:0] flash_dq_in,
	input wire logic erase_go,
	input wire logic [fcp_pkg::ADDR_W-1:0] erase_addr,
	input wire logic [31:0] busy_len,
	input wire logic [1:0] end_mode,
	output logic [fcp_pkg::ADDR_W-1:0] prog_addr,
	output logic [fcp_pkg::DATA_W-1:0] prog_byte,
	output logic [7:0] n_bad
);
	import fcp_pkg::*;
	logic [ADDR_W-1:0] wa = '0;
	logic [4:0] sec = '0;
	logic [DATA_W-1:0] wd = '0, tgt = '0, rd_val = '0;
	logic [1:0] step = '0;
	logic busy = 1'b0, erasing = 1'b0, tog = 1'b0, tflag = 1'b0, prev_we = 1'b1, prev_oe = 1'b1;
	logic [31:0] timer = '0;
	logic [ADDR_W-1:0] tgt_addr = '0;
	logic [DATA_W-1:0] tgt_byte = '0;
	logic [7:0] bad_cnt = '0;
	// One driver for each reported value
	assign prog_addr = tgt_addr;
	assign prog_byte = tgt_byte;
	assign n_bad = bad_cnt;
	// Released bus shows the inverse of the last byte
	assign flash_dq_in = (!flash_oe_n && !flash_ce_n) ? rd_val : ~rd_val;
	// Pins are looked at mid-cycle, where they are settled
	always @(negedge clock)
	begin
		prev_we <= flash_we_n;
		prev_oe <= flash_oe_n;
		if (!flash_we_n && !flash_ce_n)
		begin
			wa <= flash_addr;
			wd <= flash_dq_out;
		end
		// Busy time, then finish, or raise the overrun flag and hold it
		if (busy && timer != 0)
			timer <= timer - 1;
		else if (busy && !tflag && (end_mode == 2'd1 || end_mode == 2'd2))
			tflag <= 1'b1;
		else if (busy && end_mode == 2'd0)
			busy <= 1'b0;
		// Four writes unlock and start a byte program
		if (flash_we_n && !prev_we)
		begin
			step <= 2'd0;
			if (step == 2'd0 && wa == UNLOCK_ADDR1 && wd == UNLOCK_DATA1)
				step <= 2'd1;
			if (step == 2'd1 && wa == UNLOCK_ADDR2 && wd == UNLOCK_DATA2)
				step <= 2'd2;
			if (step == 2'd2 && wa == UNLOCK_ADDR1 && wd == PROGRAM_CMD)
				step <= 2'd3;
			if (step == 2'd3)
			begin
				tgt_addr <= wa;
				tgt_byte <= wd;
				tgt <= wd;
				erasing <= 1'b0;
				busy <= 1'b1;
				tflag <= 1'b0;
				timer <= busy_len;
			end
		end
		// Sector erase already under way, as the bench commands
		if (erase_go)
		begin
			sec <= erase_addr[ADDR_W-1:16];
			tgt <= 8'hff;
			erasing <= 1'b1;
			busy <= 1'b1;
			tflag <= 1'b0;
			timer <= busy_len;
		end
		// Reads give status while busy, memory data otherwise
		if (!flash_oe_n && prev_oe && !flash_ce_n)
		begin
			if (busy)
			begin
				rd_val <= {~tgt[7], tog, tflag, 5'h00};
				tog <= ~tog;
				if (tflag && end_mode == 2'd2)
					busy <= 1'b0;
				if (erasing ? flash_addr[ADDR_W-1:16] != sec : flash_addr != prog_addr)
					bad_cnt <= bad_cnt + 8'd1;
			end
			else
				rd_val <= (!erasing && flash_addr == prog_addr) ? prog_byte : 8'hff;
		end
		// Host must not drive while the device does
		if (!flash_oe_n && flash_dq_oe)
			bad_cnt <= bad_cnt + 8'd1;
	end
endmodule // fcp_flash_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the flash completion polling controller
`timescale 1ns/1ps
`default_nettype none
// ****************
// Testbench
// ****************
module testbench;
	import fcp_pkg::*;
	localparam longint LIMIT = 2000;
	logic clock = 1'b0, rst_n = 1'b0, op_start = 1'b0, op_program = 1'b0, erase_go = 1'b0;
	fcp_meth_t op_method = METH_DATA;
	logic [ADDR_W-1:0] op_addr = '0;
	logic [ADDR_W-1:0] flash_addr, prog_addr;
	logic [DATA_W-1:0] op_data = '0;
	logic [DATA_W-1:0] flash_dq_in, flash_dq_out, prog_byte;
	logic op_ready, op_done, op_pass, op_watchdog, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
	logic [31:0] busy_len = 32'd50;
	logic [1:0] end_mode = 2'd0;
	logic [7:0] n_bad;
	logic [1:0] exp_q[$];
	int n_fail = 0, samples_checked = 0, cycles = 0;
	fcp_controller #(.ERASE_LIMIT_CYC(LIMIT)) fcp_controller_inst (.clock(clock), .rst_n(rst_n),
		.op_start(op_start), .op_program(op_program), .op_method(op_method), .op_addr(op_addr),
		.op_data(op_data), .op_ready(op_ready), .op_done(op_done), .op_pass(op_pass),
		.op_watchdog(op_watchdog), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
	fcp_flash_model fcp_flash_model_inst (.clock(clock), .flash_addr(flash_addr),
		.flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
		.erase_go(erase_go), .erase_addr(op_addr), .busy_len(busy_len), .end_mode(end_mode),
		.prog_addr(prog_addr), .prog_byte(prog_byte), .n_bad(n_bad));
	// Clock, 8 ns period
	initial
		forever #4 clock = ~clock;
	// Counts, prints the verdict and ends the run
	task automatic report_and_stop;
		$display("TB: %0d checks, %0d failures", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Compares one value
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (exp !== got)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Cuts a hang short
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_fail++;
			report_and_stop;
		end
	end
	// Takes the oldest expected verdict whenever one appears
	always @(negedge clock)
		if (rst_n && op_done)
		begin
			if (exp_q.size() == 0)
				cmp("unexpected done", 32'd0, 32'd1);
			else
				cmp("verdict", {30'd0, exp_q.pop_front()}, {30'd0, op_watchdog, op_pass});
		end
	// One operation: mode 0 finishes, 1 overruns, 2 finishes with the flag, 3 hangs
	task automatic run_op(input logic prog, input fcp_meth_t meth, input logic [1:0] mode);
		do @(negedge clock); while (op_ready !== 1'b1);
		@(posedge clock);
		op_program <= prog;
		op_method <= meth;
		op_data <= prog ? DATA_W'($urandom) : 8'hff;
		op_addr <= ADDR_W'($urandom);
		end_mode <= mode;
		busy_len <= 32'd20 + ($urandom % 280);
		erase_go <= !prog;
		exp_q.push_back(mode == 2'd3 ? 2'b10 : {1'b0, mode != 2'd1});
		op_start <= 1'b1;
		@(posedge clock);
		op_start <= 1'b0;
		erase_go <= 1'b0;
		do @(negedge clock); while (op_done !== 1'b1);
		if (prog)
			cmp("program target", {3'd0, op_addr, op_data}, {3'd0, prog_addr, prog_byte});
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(32'ha200));
		repeat (6) @(posedge clock);
		cmp("reset pins", 32'h1e, {27'd0, op_ready, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe});
		rst_n <= 1'b1;
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 2; m++)
				for (int k = 0; k < 3; k++)
					run_op(p[0], fcp_meth_t'(m), k[1:0]);
		run_op(1'b1, METH_DATA, 2'd3);
		run_op(1'b1, METH_TOGGLE, 2'd0);
		repeat (4) @(negedge clock);
		cmp("left over", 32'd0, exp_q.size());
		cmp("poll address and bus", 32'd0, {24'd0, n_bad});
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
